// >>> rtl/can_macro_shutdown_buffer_owner.sv
/*
 * global macro switch-off (normal and forced), ready-bit semaphore and
 * ownership of the upper shared buffers between tester and listen channels.
 * assumes the host access port is synchronous to clk_in, one access per
 * cycle, and that buffer storage itself lives outside this block.
 */
`timescale 1ns/1ps
module can_macro_shutdown_buffer_owner (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// global macro control access
	input wire logic ctrl_wr_in,
	input wire logic ctrl_rd_in,
	input wire logic ctrl_set_operate_in,
	input wire logic ctrl_clr_operate_in,
	input wire logic ctrl_set_forced_in,
	input wire logic ctrl_clr_forced_in,
	input wire logic other_access_in,
	// host buffer access
	input wire logic buf_wr_in,
	input wire logic [can_gate_pkg::BUF_IDX_W-1:0] buf_idx_in,
	input wire logic ready_wr_in,
	input wire logic ready_val_in,
	// protocol side
	input wire logic tester_init_in,
	input wire logic listen_init_in,
	input wire logic [2:0] listen_mode_in,
	input wire logic [1:0] listen_ps_in,
	input wire logic chan_req_in,
	input wire logic chan_listen_in,
	input wire logic [can_gate_pkg::BUF_IDX_W-1:0] chan_idx_in,
	input wire logic chan_store_in,
	input wire logic new_data_in,
	input wire logic tester_tx_in,
	input wire logic listen_tx_in,
	// outputs
	output logic global_operate_out,
	output logic forced_shutdown_enable_out,
	output logic force_init_out,
	output logic buf_wr_ok_out,
	output logic chan_grant_out,
	output logic upper_owner_listen_out,
	output logic tester_tx_out,
	output logic listen_tx_out,
	output logic [can_gate_pkg::NUM_BUFFERS-1:0] ready_out
);
	logic global_operate;
	logic forced_shutdown_enable;
	logic armed_last;
	logic next_owner_listen;
	logic chan_ok;
	can_gate_pkg::owner_t owner;
	buf_req_if req ();

	ready_table #(
		.DEPTH(can_gate_pkg::NUM_BUFFERS)
	) u_ready (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.req(req)
	);

	// ************************************************************
	// global operate and forced shutdown
	// ************************************************************
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
			global_operate <= can_gate_pkg::GLOBAL_OPERATE_RESET;
		else if (ctrl_wr_in && ctrl_set_operate_in && !global_operate)
			global_operate <= 1'b1;
		else if (ctrl_wr_in && ctrl_clr_operate_in && global_operate)
		begin
			// forced only counts if armed by the immediately preceding access
			if (forced_shutdown_enable && armed_last)
				global_operate <= 1'b0;
			else if (tester_init_in && listen_init_in)
				global_operate <= 1'b0;
			// otherwise the request is dropped
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
			forced_shutdown_enable <= can_gate_pkg::FORCED_ENABLE_RESET;
		else if (ctrl_wr_in && ctrl_set_forced_in)
			forced_shutdown_enable <= 1'b1;
		else if (ctrl_wr_in && ctrl_clr_forced_in)
			forced_shutdown_enable <= 1'b0;
		else if (forced_shutdown_enable && (ctrl_rd_in || other_access_in || ctrl_wr_in
			|| buf_wr_in || ready_wr_in))
			forced_shutdown_enable <= 1'b0;
	end

	// ************************************************************
	// forced arm window
	// ************************************************************
	// the arm only counts for the very next access, whatever it is:
	// buffer and ready-bit writes disarm as surely as register accesses,
	// so a stray access from an interrupt handler between the arming
	// write and the clearing write can never leave the macro armed.
	// idle cycles between the two writes do not disarm, since the host
	// port only sees accesses, not the instructions between them.
	// the clearing write itself also drops the arm, so a second clear
	// later on is a normal switch-off again and needs all modules in init.

	// marks that the last access was the arming write
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
			armed_last <= 1'b0;
		else if (ctrl_wr_in || ctrl_rd_in || other_access_in || buf_wr_in || ready_wr_in)
			armed_last <= ctrl_wr_in && ctrl_set_forced_in && !ctrl_clr_operate_in;
	end

	// ************************************************************
	// ready semaphore and buffer ownership
	// ************************************************************
	// buffers are untouched by switch-off: contents stay undefined
	// ready writes are dropped while the macro is off; the table keeps
	// whatever it held, which software must treat as undefined anyway
	assign req.wr = ready_wr_in && global_operate;
	assign req.set = ready_val_in;
	assign req.idx = buf_idx_in;

	always_comb
	begin
		next_owner_listen = 1'b0;
		if (!listen_init_in && listen_ps_in != can_gate_pkg::PS_STOP)
		begin
			unique case (listen_mode_in)
				can_gate_pkg::LISTEN_MIRROR,
				can_gate_pkg::LISTEN_MIRROR_FILTER,
				can_gate_pkg::LISTEN_RX_ONLY: next_owner_listen = 1'b1;
				default: next_owner_listen = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
			owner <= can_gate_pkg::OWNER_TESTER;
		else
			owner <= next_owner_listen ? can_gate_pkg::OWNER_LISTEN : can_gate_pkg::OWNER_TESTER;
	end

	// arbitration for one protocol-side request per cycle: the lower
	// buffers are fixed to the tester channel, the upper ones follow the
	// registered owner, so a mode change takes effect one cycle later
	always_comb
	begin
		chan_ok = global_operate && req.ready[chan_idx_in];
		if (chan_idx_in < can_gate_pkg::BUF_IDX_W'(can_gate_pkg::FIRST_SHARED))
			chan_ok = chan_ok && !chan_listen_in;
		else if (chan_idx_in < can_gate_pkg::BUF_IDX_W'(can_gate_pkg::NUM_BUFFERS))
		begin
			chan_ok = chan_ok && (chan_listen_in == (owner == can_gate_pkg::OWNER_LISTEN));
			if (chan_listen_in && chan_store_in && new_data_in)
				chan_ok = 1'b0;
		end
		else
			chan_ok = 1'b0;
	end

	// ************************************************************
	// registered outputs
	// ************************************************************
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			global_operate_out <= 1'b0;
			forced_shutdown_enable_out <= 1'b0;
			force_init_out <= 1'b1;
			buf_wr_ok_out <= 1'b0;
			chan_grant_out <= 1'b0;
			upper_owner_listen_out <= 1'b0;
			tester_tx_out <= 1'b1;
			listen_tx_out <= 1'b1;
			ready_out <= '0;
		end
		else
		begin
			global_operate_out <= global_operate;
			forced_shutdown_enable_out <= forced_shutdown_enable;
			force_init_out <= !global_operate;
			buf_wr_ok_out <= buf_wr_in && global_operate && !req.ready[buf_idx_in];
			chan_grant_out <= chan_req_in && chan_ok;
			upper_owner_listen_out <= (owner == can_gate_pkg::OWNER_LISTEN);
			tester_tx_out <= global_operate ? tester_tx_in : 1'b1;
			listen_tx_out <= global_operate ? listen_tx_in : 1'b1;
			ready_out <= req.ready;
		end
	end
endmodule

// >>> rtl/can_gate_pkg.sv
/*
 * constants and types for the global switch-off and buffer ownership block.
 * assumes a single module clock and a synchronous active-low reset.
 */
// Function
// - normal switch-off discarded unless all modules init
// - armed forced shutdown switches off at once
// - any other next access disarms forced shutdown
// - control register read disarms forced shutdown
// - buffer contents undefined after reset or switch-off
// - ready bit clear blocks channel and bridge access
// - host writes to ready buffer are ignored
// - only upper sixteen buffers change owner
// - upper buffers owned by listen channel when running
// - listen channel stopped gives tester all buffers
// - listen modes never overwrite buffers holding new data
// - switched off: transmit recessive, buffers inaccessible
// - switching on starts both modules in init
package can_gate_pkg;

	// ************************************************************
	// buffer geometry
	// ************************************************************
	localparam int NUM_BUFFERS = 48;
	localparam int NUM_SHARED = 16;
	localparam int FIRST_SHARED = NUM_BUFFERS - NUM_SHARED;
	localparam int BUF_IDX_W = 6;

	// ************************************************************
	// mode encodings and reset values
	// ************************************************************
	localparam logic [2:0] OPERATING_MODE_FIELD_INIT = 3'h0;
	localparam logic [2:0] LISTEN_MIRROR = 3'h1;
	localparam logic [2:0] LISTEN_MIRROR_FILTER = 3'h2;
	localparam logic [2:0] LISTEN_RX_ONLY = 3'h3;
	localparam logic [1:0] PS_NONE = 2'h0;
	localparam logic [1:0] PS_SLEEP = 2'h1;
	localparam logic [1:0] PS_STOP = 2'h2;
	localparam logic GLOBAL_OPERATE_RESET = 1'b0;
	localparam logic FORCED_ENABLE_RESET = 1'b0;

	typedef enum logic {OWNER_TESTER, OWNER_LISTEN} owner_t;

endpackage

// >>> rtl/buf_req_if.sv
/*
 * carries one per-buffer request from the switch-off block to the ready table.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface buf_req_if;
	logic wr;
	logic set;
	logic [can_gate_pkg::BUF_IDX_W-1:0] idx;
	logic [can_gate_pkg::NUM_BUFFERS-1:0] ready;
	modport src (output wr, output set, output idx, input ready);
	modport dst (input wr, input set, input idx, output ready);
endinterface

// >>> rtl/ready_table.sv
/*
 * per-buffer ready bits, the semaphore between host and protocol side.
 * assumes writes are already gated by the global operate state.
 */
`timescale 1ns/1ps
module ready_table #(
	parameter int DEPTH = can_gate_pkg::NUM_BUFFERS
)(
	input wire logic clk_in,
	input wire logic rst_b_in,
	buf_req_if.dst req
);
	logic [DEPTH-1:0] ready;

	genvar i;
	generate
		for (i = 0; i < DEPTH; i++)
		begin : g_bit
			always_ff @(posedge clk_in)
			begin
				if (!rst_b_in)
					ready[i] <= 1'b0;
				else if (req.wr && req.idx == can_gate_pkg::BUF_IDX_W'(i))
					ready[i] <= req.set;
			end
		end
	endgenerate

	assign req.ready = ready;
endmodule

// >>> verif/can_side_model.sv
/*
 * stand-in for the two protocol engines at the far side of the block.
 * assumes the bench says when software has asked both engines for init.
 */
`timescale 1ns/1ps
module can_side_model (
	// clock
	input wire logic clk_in,
	// requests from the bench
	input wire logic want_init_in,
	input wire logic [2:0] listen_mode_in,
	// engine state
	output logic tester_init_out,
	output logic listen_init_out,
	output logic tester_tx_out,
	output logic listen_tx_out
);
	logic ph = 1'b0;
	// the tester engine reaches init only at the next intermission
	always @(posedge clk_in)
	begin
		tester_init_out <= want_init_in;
		ph <= ~ph;
	end
	// opposite phases, so one of them is always dominant
	assign tester_tx_out = ph;
	assign listen_tx_out = ~ph;
	// bit rate is taken as matched to the monitored bus
	assign listen_init_out = want_init_in | (listen_mode_in == can_gate_pkg::OPERATING_MODE_FIELD_INIT);
endmodule

// >>> verif/can_macro_shutdown_buffer_owner_chk.sv
/*
 * port-level checks for the switch-off and buffer ownership block.
 * assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps
module can_macro_shutdown_buffer_owner_chk (
	input wire logic clk_in, rst_b_in, ctrl_wr_in, ctrl_rd_in, other_access_in,
	input wire logic ctrl_clr_operate_in, ctrl_set_forced_in, ctrl_set_operate_in,
	input wire logic tester_init_in, listen_init_in, buf_wr_in, chan_req_in,
	input wire logic chan_listen_in, chan_store_in, new_data_in,
	input wire logic [can_gate_pkg::BUF_IDX_W-1:0] buf_idx_in, chan_idx_in,
	input wire logic global_operate_out, forced_shutdown_enable_out, force_init_out,
	input wire logic buf_wr_ok_out, chan_grant_out, tester_tx_out, listen_tx_out,
	input wire logic [can_gate_pkg::NUM_BUFFERS-1:0] ready_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	tx_recessive_a: assert property (!global_operate_out |-> tester_tx_out && listen_tx_out)
		else $error("transmit not recessive while off");
	init_hold_a: assert property (force_init_out != global_operate_out)
		else $error("init hold disagrees with operate");
	normal_refuse_a: assert property (ctrl_wr_in && ctrl_clr_operate_in && !ctrl_set_operate_in
		&& !$past(ctrl_wr_in) && !forced_shutdown_enable_out && global_operate_out
		&& !(tester_init_in && listen_init_in) |=> ##1 global_operate_out)
		else $error("switch-off taken with a module running");
	forced_off_a: assert property (ctrl_wr_in && ctrl_clr_operate_in && !ctrl_set_operate_in
		&& $past(ctrl_wr_in && ctrl_set_forced_in && !ctrl_clr_operate_in)
		|=> ##1 !global_operate_out)
		else $error("forced switch-off not taken");
	forced_disarm_a: assert property ($past(ctrl_wr_in && ctrl_set_forced_in)
		&& (ctrl_rd_in || other_access_in) |=> ##1 !forced_shutdown_enable_out)
		else $error("forced arm survived another access");
	ready_blocks_wr_a: assert property (buf_wr_in ##1 ready_out[$past(buf_idx_in)]
		|-> !buf_wr_ok_out)
		else $error("write accepted into a ready buffer");
	ready_gates_chan_a: assert property (chan_req_in ##1 !ready_out[$past(chan_idx_in)]
		|-> !chan_grant_out)
		else $error("channel granted a buffer not ready");
	no_overwrite_a: assert property (chan_req_in && chan_listen_in && chan_store_in
		&& new_data_in |=> !chan_grant_out)
		else $error("listen store over new data");
	cover property (global_operate_out ##1 !global_operate_out);
	cover property (chan_grant_out && $past(chan_listen_in, 2));
	cover property (buf_wr_ok_out);
endmodule
bind can_macro_shutdown_buffer_owner can_macro_shutdown_buffer_owner_chk chk (.*);

// >>> verif/can_macro_shutdown_buffer_owner_tb_top.sv
/*
 * directed bench for the switch-off and buffer ownership block.
 * assumes the package and the far-side model are compiled first.
 */
`timescale 1ns/1ps
module can_macro_shutdown_buffer_owner_tb_top;
	logic clk_in, rst_b_in, ctrl_wr_in, ctrl_rd_in, ctrl_set_operate_in, ctrl_clr_operate_in;
	logic ctrl_set_forced_in, ctrl_clr_forced_in, other_access_in, buf_wr_in, ready_wr_in;
	logic ready_val_in, tester_init_in, listen_init_in, chan_req_in, chan_listen_in, want_init;
	logic chan_store_in, new_data_in, tester_tx_in, listen_tx_in, global_operate_out;
	logic forced_shutdown_enable_out, force_init_out, buf_wr_ok_out, chan_grant_out;
	logic upper_owner_listen_out, tester_tx_out, listen_tx_out;
	logic [5:0] buf_idx_in, chan_idx_in, c;
	logic [2:0] listen_mode_in;
	logic [1:0] listen_ps_in;
	logic [47:0] ready_out;
	int error_cnt, n_tests;
	assign {ctrl_wr_in, ctrl_rd_in, ctrl_set_operate_in, ctrl_clr_operate_in,
		ctrl_set_forced_in, other_access_in} = c;
	can_macro_shutdown_buffer_owner dut (.*);
	can_side_model far (.clk_in(clk_in), .want_init_in(want_init),
		.listen_mode_in(listen_mode_in), .tester_init_out(tester_init_in),
		.listen_init_out(listen_init_in), .tester_tx_out(tester_tx_in),
		.listen_tx_out(listen_tx_in));
	task step(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task chk(input logic got, input logic exp);
		n_tests++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error at %0t: got %b expected %b", $time, got, exp);
		end
	endtask
	// control access bits: write, read, set operate, clear operate, arm, other
	task ctl(input logic [5:0] v);
		c = v;
		step(1);
		c = 6'h00;
		step(1);
	endtask
	// two accesses back to back, nothing in between
	task ctl2(input logic [5:0] a, input logic [5:0] b);
		c = a;
		step(1);
		c = b;
		step(1);
		c = 6'h00;
		step(1);
	endtask
	task rdy(input logic [5:0] i, input logic v);
		buf_idx_in = i;
		ready_val_in = v;
		ready_wr_in = 1'b1;
		step(1);
		ready_wr_in = 1'b0;
		step(1);
	endtask
	task bw(input logic [5:0] i, input logic exp);
		buf_idx_in = i;
		buf_wr_in = 1'b1;
		step(1);
		chk(buf_wr_ok_out, exp);
		buf_wr_in = 1'b0;
		step(1);
	endtask
	task ch(input logic [2:0] v, input logic [5:0] i, input logic exp);
		{chan_listen_in, chan_store_in, new_data_in} = v;
		chan_idx_in = i;
		chan_req_in = 1'b1;
		step(1);
		chk(chan_grant_out, exp);
		chan_req_in = 1'b0;
		step(1);
	endtask
	task give_verdict;
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end
	initial
	begin
		step(3000);
		error_cnt++;
		give_verdict;
	end
	initial
	begin
		{buf_wr_in, ready_wr_in, ready_val_in, chan_req_in, want_init, rst_b_in} = 6'h00;
		{chan_listen_in, chan_store_in, new_data_in, ctrl_clr_forced_in} = 4'h0;
		{c, buf_idx_in, chan_idx_in, listen_mode_in, listen_ps_in} = 23'h0;
		error_cnt = 0;
		n_tests = 0;
		step(3);
		rst_b_in = 1'b1;
		chk(global_operate_out, 1'b0);
		chk(forced_shutdown_enable_out, 1'b0);
		rdy(6'h28, 1'b1);
		step(1);
		chk(ready_out[40], 1'b0);
		bw(6'h05, 1'b0);
		ctl(6'h28);
		step(1);
		chk(force_init_out, 1'b0);
		ctl(6'h24);
		step(1);
		chk(global_operate_out, 1'b1);
		rdy(6'h05, 1'b1);
		bw(6'h05, 1'b0);
		rdy(6'h05, 1'b0);
		bw(6'h05, 1'b1);
		ch(3'h2, 6'h05, 1'b0);
		rdy(6'h05, 1'b1);
		rdy(6'h28, 1'b1);
		ch(3'h2, 6'h05, 1'b1);
		ch(3'h6, 6'h05, 1'b0);
		// owner of upper buffers follows listen mode and power state
		for (int m = 0; m < 4; m++)
			for (int p = 0; p < 3; p++)
			begin
				listen_mode_in = m[2:0];
				listen_ps_in = p[1:0];
				step(4);
				chk(upper_owner_listen_out, m != 0 && p != 2);
				if (m == 1 && p == 0)
				begin
					ch(3'h7, 6'h28, 1'b0);
					ch(3'h6, 6'h28, 1'b1);
					ch(3'h2, 6'h28, 1'b0);
				end
			end
		ch(3'h2, 6'h28, 1'b1);
		ctl2(6'h22, 6'h10);
		step(1);
		chk(forced_shutdown_enable_out, 1'b0);
		ctl(6'h24);
		step(1);
		chk(global_operate_out, 1'b1);
		ctl(6'h22);
		step(1);
		chk(forced_shutdown_enable_out, 1'b1);
		ctl2(6'h00, 6'h01);
		step(1);
		chk(forced_shutdown_enable_out, 1'b0);
		ctl2(6'h22, 6'h01);
		step(1);
		chk(forced_shutdown_enable_out, 1'b0);
		ctl2(6'h22, 6'h24);
		step(1);
		chk(global_operate_out, 1'b0);
		chk(tester_tx_out & listen_tx_out, 1'b1);
		ctl(6'h28);
		want_init = 1'b1;
		step(2);
		ctl(6'h24);
		step(1);
		chk(global_operate_out, 1'b0);
		give_verdict;
	end
endmodule
